// ### rtl/edi_pkg.sv
// Purpose: Constants for the eight-channel discrete input conditioning block.
// Assumes: One clock MCLK at 10 MHz; parameters arrive as a byte stream.
// Notes: Timing counts assume the 100 ns clock period below.
// Operation
// RL1: Channels 1-4 go to input byte 2, state even bit, fault odd bit.
// RL2: Channels 5-8 go to input byte 1 with the same pairing.
// RL3: Refreshed input bytes are handed over every 6.5 ms.
// RL4: Each channel tracks input changes up to 50 Hz.
// RL5: Accept only config code 0x11, header 0x19, then three parameter bytes.
// RL6: First parameter byte bits 0-7 enable line fault detection, channels 1-8.
// RL7: Second byte bit 0 inverts channels 1-4; bit 1 is ignored.
// RL8: Second byte bits 2-3 select contact type: proximity, 24 V, 5 V.
// RL9: Second byte bits 4-5 select switch-on delay: none, 10, 100, 1000 ms.
// RL10: Second byte bits 6-7 select switch-off delay with the same codes.
// RL11: Third byte applies the same layout to channels 5-8.
// RL12: Switch-on delay suppresses high pulses shorter than the delay.
// RL13: Switch-off delay holds a high level for the delay after a fall.
// RL14: Inversion reports the complement, otherwise positive logic.
// RL15: Detect wire break and short on enabled proximity channels, per channel.
// RL16: Master picks active contact types only with fault detection off.
// RL17: Active contact types work only with the support option enabled.
// RL18: Master must use the configuration held by the station.
// RL19: After reset: no fault detection, no inversion, proximity, no delays.
// RL20: With fault detection off, the fault flag reads 0.
`default_nettype none
package edi_pkg;
	localparam int NCH = 8;
	localparam logic [7:0] CFG_CODE = 8'h11;
	localparam logic [7:0] PRM_HDR = 8'h19;
	// Group config byte field positions.
	localparam int INV_BIT = 0;
	localparam int CT_LSB = 2;
	localparam int ON_LSB = 4;
	localparam int OFF_LSB = 6;
	localparam logic [7:0] LFD_RST = 8'h00;
	localparam logic [7:0] GRP_RST = 8'h00;
	// Contact type codes.
	localparam logic [1:0] CT_PROX = 2'h0;
	localparam logic [1:0] CT_24V = 2'h1;
	localparam logic [1:0] CT_5V = 2'h2;
	// Delay in milliseconds per code.
	localparam logic [9:0] DLY_C1_MS = 10'h00a;
	localparam logic [9:0] DLY_C2_MS = 10'h064;
	localparam logic [9:0] DLY_C3_MS = 10'h3e8;
	// Timing.
	localparam int CLK_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int XFER_US = 6500;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int XFER_CYC = (XFER_US * 1000) / CLK_NS;
	typedef enum logic [4:0] {
		PS_CODE = 5'b00001,
		PS_HDR = 5'b00010,
		PS_B1 = 5'b00100,
		PS_B2 = 5'b01000,
		PS_B3 = 5'b10000
	} edi_pst_t;
endpackage
`default_nettype wire

// ### rtl/edi_top.sv
// Purpose: Eight-channel discrete input conditioning and status packing.
// Assumes: Parameter bytes come from logic on MCLK; field inputs are asynchronous.
// Notes: Delays are timed on a 1 ms tick, so each delay carries up to 1 ms of jitter.
`default_nettype none
module edi_top #(
	parameter int MS_CYCLES = edi_pkg::MS_CYC,
	parameter int XFER_CYCLES = edi_pkg::XFER_CYC
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] PRM_BYTE,
	input wire logic PRM_VALID,
	input wire logic ACTIVE_SUPPORT,
	input wire logic [edi_pkg::NCH-1:0] PROX_LEVEL,
	input wire logic [edi_pkg::NCH-1:0] PROX_BREAK,
	input wire logic [edi_pkg::NCH-1:0] PROX_SHORT,
	input wire logic [edi_pkg::NCH-1:0] ACTIVE_LEVEL,
	output logic [7:0] IN_BYTE1,
	output logic [7:0] IN_BYTE2,
	output logic XFER_STB,
	output logic PRM_DONE,
	output logic PRM_ERR
);
	import edi_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [4*NCH-1:0] sync1_q;
	logic [4*NCH-1:0] sync2_q;
	logic [NCH-1:0] prox_s;
	logic [NCH-1:0] brk_s;
	logic [NCH-1:0] shrt_s;
	logic [NCH-1:0] act_s;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {ACTIVE_LEVEL, PROX_SHORT, PROX_BREAK, PROX_LEVEL};
			sync2_q <= sync1_q;
		end
	end

	assign prox_s = sync2_q[NCH-1:0];
	assign brk_s = sync2_q[2*NCH-1:NCH];
	assign shrt_s = sync2_q[3*NCH-1:2*NCH];
	assign act_s = sync2_q[4*NCH-1:3*NCH];

	// ------------------------------------------------------------
	// Parameter sequence decoder
	// ------------------------------------------------------------
	edi_pst_t pst_q;
	logic [7:0] lfd_q;
	logic [7:0] grp_lo_q;
	logic [7:0] grp_hi_q;
	logic [7:0] lfd_tmp_q;
	logic [7:0] lo_tmp_q;

	// A sequence is only applied once all three bytes arrived, so a broken
	// sequence never leaves the channels half configured.
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pst_q <= PS_CODE;
			lfd_q <= LFD_RST; // RL19
			grp_lo_q <= GRP_RST; // RL19
			grp_hi_q <= GRP_RST; // RL19
			lfd_tmp_q <= LFD_RST;
			lo_tmp_q <= GRP_RST;
			PRM_DONE <= 1'b0;
			PRM_ERR <= 1'b0;
		end else if (PRM_VALID) begin
			unique case (pst_q)
				PS_CODE: begin
					if (PRM_BYTE == CFG_CODE) begin // RL5
						pst_q <= PS_HDR;
						PRM_ERR <= 1'b0;
					end else begin
						PRM_ERR <= 1'b1;
					end
				end
				PS_HDR: begin
					if (PRM_BYTE == PRM_HDR) begin // RL5
						pst_q <= PS_B1;
					end else begin
						pst_q <= PS_CODE;
						PRM_ERR <= 1'b1;
					end
				end
				PS_B1: begin
					lfd_tmp_q <= PRM_BYTE;
					pst_q <= PS_B2;
				end
				PS_B2: begin
					lo_tmp_q <= PRM_BYTE;
					pst_q <= PS_B3;
				end
				PS_B3: begin
					lfd_q <= lfd_tmp_q; // RL6
					grp_lo_q <= lo_tmp_q;
					grp_hi_q <= PRM_BYTE; // RL11
					PRM_DONE <= 1'b1;
					pst_q <= PS_CODE;
				end
				default: begin
					pst_q <= PS_CODE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Millisecond timebase
	// ------------------------------------------------------------
	logic [31:0] ms_cnt_q;
	logic ms_tick;

	assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ms_cnt_q <= '0;
		end else if (ms_tick) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_q + 32'h1;
		end
	end

	function automatic logic [9:0] dly_ms(input logic [1:0] code);
		logic [9:0] r;
		r = '0;
		unique case (code)
			2'h0: r = '0;
			2'h1: r = DLY_C1_MS;
			2'h2: r = DLY_C2_MS;
			2'h3: r = DLY_C3_MS;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// Per-channel conditioning
	// ------------------------------------------------------------
	logic [NCH-1:0] stat;
	logic [NCH-1:0] flt;

	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			logic [7:0] grp;
			logic [1:0] ct;
			logic use_act;
			logic is_prox;
			logic raw;
			logic [9:0] on_ms;
			logic [9:0] off_ms;
			logic [9:0] lim;
			logic filt_q;
			logic [9:0] cnt_q;

			assign grp = (i < 4) ? grp_lo_q : grp_hi_q; // RL11
			assign ct = grp[CT_LSB +: 2]; // RL8
			// Active types need the station option; else proximity handling.
			assign use_act = ACTIVE_SUPPORT && (ct == CT_24V || ct == CT_5V); // RL17
			// Code 3 is undefined and falls back to proximity handling.
			assign is_prox = !use_act;
			assign raw = use_act ? act_s[i] : prox_s[i];
			assign on_ms = dly_ms(grp[ON_LSB +: 2]); // RL9
			assign off_ms = dly_ms(grp[OFF_LSB +: 2]); // RL10
			assign lim = filt_q ? off_ms : on_ms;

			// Mismatch must persist for the delay before the state moves.
			always_ff @(posedge MCLK or posedge RST) begin
				if (RST) begin
					filt_q <= 1'b0;
					cnt_q <= '0;
				end else if (raw == filt_q) begin
					cnt_q <= '0;
				end else if (lim == '0) begin
					filt_q <= raw; // RL4
					cnt_q <= '0;
				end else if (ms_tick) begin
					if (cnt_q + 10'h1 >= lim) begin
						filt_q <= raw; // RL12 RL13
						cnt_q <= '0;
					end else begin
						cnt_q <= cnt_q + 10'h1;
					end
				end
			end

			assign stat[i] = filt_q ^ grp[INV_BIT]; // RL14 RL7
			assign flt[i] = lfd_q[i] && is_prox && (brk_s[i] || shrt_s[i]); // RL15 RL20
		end
	endgenerate

	// ------------------------------------------------------------
	// Packing and periodic hand-over
	// ------------------------------------------------------------
	logic [31:0] xf_cnt_q;
	logic xf_tick;
	logic [7:0] b1_d;
	logic [7:0] b2_d;

	assign xf_tick = (xf_cnt_q == 32'(XFER_CYCLES - 1));

	always_comb begin
		b1_d = '0;
		b2_d = '0;
		for (int k = 0; k < 4; k++) begin
			b2_d[2*k] = stat[k]; // RL1
			b2_d[2*k+1] = flt[k]; // RL1
			b1_d[2*k] = stat[k+4]; // RL2
			b1_d[2*k+1] = flt[k+4]; // RL2
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			xf_cnt_q <= '0;
			IN_BYTE1 <= '0;
			IN_BYTE2 <= '0;
			XFER_STB <= 1'b0;
		end else begin
			XFER_STB <= xf_tick;
			if (xf_tick) begin
				xf_cnt_q <= '0;
				IN_BYTE1 <= b1_d; // RL3
				IN_BYTE2 <= b2_d; // RL3
			end else begin
				xf_cnt_q <= xf_cnt_q + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/edi_checker.sv
// Purpose: Port checks for the input conditioning block.
// Assumes: The master idles a cycle before each frame.
// Notes: The first strobe is skipped; only later periods are timed.
`default_nettype none
module edi_checker #(
	parameter int XFER_CYCLES = 50
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] PRM_BYTE,
	input wire logic PRM_VALID,
	input wire logic [7:0] IN_BYTE1,
	input wire logic [7:0] IN_BYTE2,
	input wire logic XFER_STB,
	input wire logic PRM_DONE,
	input wire logic PRM_ERR
);
	import edi_pkg::*;
	int cnt_q;
	logic seen_q;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cnt_q <= 0;
			seen_q <= 1'b0;
		end else begin
			cnt_q <= XFER_STB ? 1 : cnt_q + 1;
			seen_q <= seen_q | XFER_STB;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	sequence s_code;
		!PRM_VALID ##1 PRM_VALID && PRM_BYTE == CFG_CODE;
	endsequence
	sequence s_good;
		s_code ##1 PRM_VALID && PRM_BYTE == PRM_HDR ##1 PRM_VALID [*3];
	endsequence
	a_done_after_frame: assert property (s_good |=> PRM_DONE && !PRM_ERR)
		else $error("frame not applied");
	a_done_sticky: assert property (PRM_DONE |=> PRM_DONE)
		else $error("done dropped");
	a_code_refused: assert property (!PRM_VALID ##1 PRM_VALID && PRM_BYTE != CFG_CODE |=> PRM_ERR)
		else $error("bad code accepted");
	a_hdr_refused: assert property (s_code ##1 PRM_VALID && PRM_BYTE != PRM_HDR |=> PRM_ERR)
		else $error("bad header accepted");
	a_err_cleared: assert property (s_code |=> !PRM_ERR)
		else $error("error not cleared");
	a_bytes_held: assert property (!XFER_STB |-> $stable(IN_BYTE1) && $stable(IN_BYTE2))
		else $error("bytes changed off strobe");
	a_period_exact: assert property (seen_q |-> cnt_q <= XFER_CYCLES && XFER_STB == (cnt_q == XFER_CYCLES))
		else $error("transfer period wrong");
	a_reset_clear: assert property ($fell(RST) |-> !XFER_STB && !PRM_DONE && !PRM_ERR && {IN_BYTE1, IN_BYTE2} == 16'h0000)
		else $error("outputs not clear after reset");
endmodule
bind edi_top edi_checker #(.XFER_CYCLES(XFER_CYCLES)) i_chk (.MCLK(MCLK), .RST(RST),
	.PRM_BYTE(PRM_BYTE), .PRM_VALID(PRM_VALID), .IN_BYTE1(IN_BYTE1), .IN_BYTE2(IN_BYTE2),
	.XFER_STB(XFER_STB), .PRM_DONE(PRM_DONE), .PRM_ERR(PRM_ERR));
`default_nettype wire

// ### test/edi_master.sv
// Purpose: Fieldbus master model sending one five-byte frame per request.
// Assumes: go is raised for one cycle while the model is idle.
// Notes: Idle data toggles so a stale byte never looks valid.
`default_nettype none
module edi_master (
	input wire logic MCLK,
	input wire logic go,
	input wire logic [39:0] frame,
	output logic [7:0] PRM_BYTE,
	output logic PRM_VALID
);
	logic [39:0] sh_q;
	int n_q = 0;
	initial begin
		PRM_BYTE = 8'h00;
		PRM_VALID = 1'b0;
	end
	always @(posedge MCLK) begin
		if (n_q > 0) begin
			PRM_VALID <= 1'b1;
			PRM_BYTE <= sh_q[39:32];
			sh_q <= sh_q << 8;
			n_q <= n_q - 1;
		end else begin
			PRM_VALID <= 1'b0;
			PRM_BYTE <= ~PRM_BYTE;
			if (go) begin
				sh_q <= frame;
				n_q <= 5;
			end
		end
	end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the input conditioning block.
// Assumes: 10 cycles a millisecond and 50 cycles a transfer period.
// Notes: Random frames keep delays off; a second loop times delay codes 1-3.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import edi_pkg::*;
	logic MCLK = 1'b0, RST = 1'b1, go = 1'b0, sup = 1'b0, pv, stb, done, err;
	logic [7:0] pb, b1, b2, lf = 8'h00, g1 = 8'h00, g2 = 8'h00, d1, d2, d3;
	logic [7:0] lvl = 8'h00, brk = 8'h00, sht = 8'h00, act = 8'h00;
	logic [39:0] frame = '0;
	logic [15:0] q[$];
	int fail_count = 0, compares = 0, seed = 86483;
	edi_top #(.MS_CYCLES(10), .XFER_CYCLES(50)) i_dut (.MCLK(MCLK), .RST(RST), .PRM_BYTE(pb),
		.PRM_VALID(pv), .ACTIVE_SUPPORT(sup), .PROX_LEVEL(lvl), .PROX_BREAK(brk),
		.PROX_SHORT(sht), .ACTIVE_LEVEL(act), .IN_BYTE1(b1), .IN_BYTE2(b2), .XFER_STB(stb),
		.PRM_DONE(done), .PRM_ERR(err));
	edi_master i_mst (.MCLK(MCLK), .go(go), .frame(frame), .PRM_BYTE(pb), .PRM_VALID(pv));
	initial begin
		forever #50 MCLK = ~MCLK;
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask
	task automatic end_sim;
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_stb(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			do begin
				@(posedge MCLK);
				#1;
				t++;
			end while (stb !== 1'b1 && t < 100);
			if (stb !== 1'b1) begin
				fail_count++;
				end_sim();
			end
		end
		#9;
	endtask
	task automatic send(input logic [7:0] c, input logic [7:0] h);
		frame = {c, h, d1, d2, d3};
		go = 1'b1;
		@(posedge MCLK);
		#10 go = 1'b0;
	endtask
	task automatic step(input logic [7:0] v, input logic [15:0] h, input logic [15:0] f, input int n);
		wait_stb(1);
		lvl = v;
		q.push_back(h);
		wait_stb(n + 1);
		q.push_back(f);
	endtask
	function automatic logic [15:0] expect_bytes();
		logic [15:0] r;
		logic [7:0] g;
		logic a;
		for (int c = 0; c < NCH; c++) begin
			g = (c < 4) ? g1 : g2;
			a = sup && (g[3:2] == CT_24V || g[3:2] == CT_5V);
			r[2 * c] = (a ? act[c] : lvl[c]) ^ g[INV_BIT];
			r[2 * c + 1] = lf[c] && !a && (brk[c] || sht[c]);
		end
		return r;
	endfunction
	// Outputs are read just after the edge that launches them, never in its time step.
	always @(posedge MCLK) begin
		#1;
		if (stb === 1'b1 && q.size() > 0)
			chk("in_bytes", {b1, b2}, q.pop_front());
	end
	initial begin
		repeat (6) @(posedge MCLK);
		#10 RST = 1'b0;
		for (int i = 0; i < 16; i++) begin
			wait_stb(1);
			{lvl, brk, sht, act} = $random(seed);
			sup = 1'($random(seed));
			d1 = 8'($random(seed));
			d2 = 8'($random(seed)) & 8'h0f;
			d3 = 8'($random(seed)) & 8'h0f;
			// Active contact types are only chosen with fault detection off.
			if (d2[3:2] inside {CT_24V, CT_5V}) d1[3:0] = 4'h0;
			if (d3[3:2] inside {CT_24V, CT_5V}) d1[7:4] = 4'h0;
			if (i % 8 == 7) begin
				{d1, d2, d3} = '0;
				send(CFG_CODE ^ 8'h02, PRM_HDR);
			end else if (i % 4 == 3) begin
				send(CFG_CODE, PRM_HDR ^ 8'h01);
			end else if (i > 0) begin
				send(CFG_CODE, PRM_HDR);
				{lf, g1, g2} = {d1, d2, d3};
			end
			q.push_back(expect_bytes());
			repeat (8) @(posedge MCLK);
			#1;
			chk("prm_err", {15'h0000, err}, {15'h0000, i % 4 == 3});
			chk("prm_done", {15'h0000, done}, {15'h0000, i > 0});
		end
		for (int k = 1; k < 4; k++) begin
			wait_stb(1);
			{lvl, brk, sht, act, sup} = '0;
			{d1, d2, d3} = {8'h00, 8'(k * 80), 8'h00};
			send(CFG_CODE, PRM_HDR);
			{lf, g1, g2} = {d1, d2, d3};
			step(8'h01, 16'h0000, 16'h0001, (10 ** k) / 5);
			step(8'h00, 16'h0001, 16'h0000, (10 ** k) / 5);
		end
		end_sim();
	end
endmodule
`default_nettype wire
